// [inc/maot_pkg.sv]
// Package: register map, reset values, field positions and timing for the alert/timer bank
package maot_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] MAOT_OFS_MASK_VT = 8'h74;
  localparam logic [7:0] MAOT_OFS_MASK_FD = 8'h75;
  localparam logic [7:0] MAOT_OFS_LOW_VOLT = 8'h76;
  localparam logic [7:0] MAOT_OFS_LOW_TEMP = 8'h77;
  localparam logic [7:0] MAOT_OFS_CONFIG = 8'h78;
  localparam logic [7:0] MAOT_OFS_OT_TIMER = 8'h79;
  localparam logic [7:0] MAOT_OFS_OT_LIMIT = 8'h7a;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MAOT_RST_MASK_VT = 8'h00;
  localparam logic [7:0] MAOT_RST_MASK_FD = 8'h00;
  localparam logic [7:0] MAOT_RST_LOW = 8'h00;
  localparam logic [7:0] MAOT_RST_CONFIG = 8'h00;
  localparam logic [7:0] MAOT_RST_OT_TIMER = 8'h00;
  localparam logic [7:0] MAOT_RST_OT_LIMIT = 8'hff;

  // ----------------------------------------------------------------
  // Writable-bit masks and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] MAOT_WMASK_MASK_VT = 8'h7f;
  localparam logic [7:0] MAOT_WMASK_MASK_FD = 8'hfd;
  localparam logic [7:0] MAOT_WMASK_CFG_LOCKABLE = 8'h0b;
  localparam logic [7:0] MAOT_WMASK_CFG_FREE = 8'hf0;
  localparam int MAOT_CFG_ALERT_SEL = 0;
  localparam int MAOT_CFG_OT_ENABLE = 1;
  localparam int MAOT_CFG_TACH_FAST = 3;
  localparam int MAOT_CFG_CONT_LSB = 4;

  // ----------------------------------------------------------------
  // Timing at a 10 ns clock
  // ----------------------------------------------------------------
  localparam int unsigned MAOT_CLK_PERIOD_NS = 10;
  localparam int unsigned MAOT_OT_STEP_NS = 22760000;
  localparam int unsigned MAOT_OT_VISIBLE_NS = 45520000;
  localparam int unsigned MAOT_OT_STEP_CYCLES = MAOT_OT_STEP_NS / MAOT_CLK_PERIOD_NS;
  localparam logic [7:0] MAOT_OT_VISIBLE_STEPS = 8'(MAOT_OT_VISIBLE_NS / MAOT_OT_STEP_NS);
  localparam int unsigned MAOT_TACH_SLOW_MS = 1000;
  localparam int unsigned MAOT_TACH_FAST_MS = 250;

endpackage : maot_pkg

// [inc/maot_timer_if.sv]
// Interface: link between the register bank and the overtemperature timer
`timescale 1ns/1ps
interface maot_timer_if;
  logic pin_active;
  logic read_clear;
  logic [7:0] limit;
  logic [7:0] value;
  logic limit_hit;

  modport bank (output pin_active, output read_clear, output limit, input value, input limit_hit);
  modport timer (input pin_active, input read_clear, input limit, output value, output limit_hit);
endinterface : maot_timer_if

// [rtl/maot_overtemp_timer.sv]
// Module: overtemperature assertion timer with limit detection
`timescale 1ns/1ps
module maot_overtemp_timer
  import maot_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = MAOT_OT_STEP_CYCLES
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Bank side
  maot_timer_if.timer tif
);

  logic pin_prev;
  logic [31:0] cyc;
  logic [7:0] steps;
  logic asserted_flag;
  logic hit_prev;
  logic rise;
  logic hit_now;

  assign rise = tif.pin_active & ~pin_prev;

  // ----------------------------------------------------------------
  // Edge tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_prev <= 1'b0;
    end else if (ce) begin
      pin_prev <= tif.pin_active;
    end
  end

  // ----------------------------------------------------------------
  // Asserted flag: an edge in the read cycle still sets it
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      asserted_flag <= 1'b0;
    end else if (ce) begin
      if (rise) begin
        asserted_flag <= 1'b1;
      end else if (tif.read_clear) begin
        asserted_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Duration count, saturating at full scale
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc <= '0;
      steps <= MAOT_RST_OT_TIMER;
    end else if (ce) begin
      if (rise) begin
        cyc <= '0;
      end else if (tif.pin_active) begin
        if (cyc >= STEP_CYCLES - 1) begin
          cyc <= '0;
        end else begin
          cyc <= cyc + 32'd1;
        end
      end
      if (tif.read_clear) begin
        steps <= '0;
      end else if (tif.pin_active && !rise && cyc >= STEP_CYCLES - 1 && steps != 8'hff) begin
        steps <= steps + 8'd1;
      end
    end
  end

  // Below the visible threshold only the asserted flag shows
  assign tif.value = (steps >= MAOT_OT_VISIBLE_STEPS) ? steps : {7'h00, asserted_flag};

  // ----------------------------------------------------------------
  // Limit comparison; zero limit fires on the assertion edge
  // ----------------------------------------------------------------
  assign hit_now = tif.pin_active & ((tif.limit == 8'h00) | (steps > tif.limit));

  always_ff @(posedge clk) begin
    if (rst) begin
      hit_prev <= 1'b0;
    end else if (ce) begin
      hit_prev <= hit_now;
    end
  end

  assign tif.limit_hit = ce & hit_now & ~hit_prev;

endmodule : maot_overtemp_timer

// [rtl/maot_alert_timer_regs.sv]
// Module: alert masks, extended-resolution, pin/tach config and overtemp timer registers
`timescale 1ns/1ps
module maot_alert_timer_regs
  import maot_pkg::*;
#(
  parameter int unsigned OT_STEP_CYCLES = MAOT_OT_STEP_CYCLES
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // Register access port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Global lock bit
  input wire logic LOCK,
  // Out-of-limit status from the monitor (bit7 of first group unused)
  input wire logic [7:0] VOLT_TEMP_EVENTS,
  input wire logic [7:0] FAN_DIODE_EVENTS,
  // Conversion results, low bits
  input wire logic [7:0] LOW_BITS_VOLT_IN,
  input wire logic [7:0] LOW_BITS_TEMP_IN,
  // High-byte register reads, one strobe per channel
  input wire logic [3:0] HIGH_VOLT_READ,
  input wire logic [3:0] HIGH_TEMP_READ,
  output logic FREEZE_VOLT_HIGH,
  output logic FREEZE_TEMP_HIGH,
  // Shared alert / fan drive pin (open drain in alert mode)
  input wire logic SECOND_FAN_DRIVE,
  output logic SHARED_PIN_OUT,
  output logic SHARED_PIN_OE,
  // Overtemperature pin, active low, asynchronous
  input wire logic OVERTEMP_PIN_N,
  output logic OVERTEMP_LIMIT_FLAG,
  input wire logic OVERTEMP_FLAG_CLEAR,
  // Tach configuration
  output logic TACH_FAST,
  output logic [3:0] TACH_CONTINUOUS
);

  maot_timer_if tif ();

  logic [7:0] alert_mask_volt_temp;
  logic [7:0] alert_mask_fan_diode;
  logic [7:0] low_bits_voltages;
  logic [7:0] low_bits_12v_temps;
  logic [7:0] pin_and_tach_config;
  logic [7:0] overtemp_duration_limit;
  logic [3:0] pend_volt;
  logic [3:0] pend_temp;
  logic ot_meta;
  logic ot_sync;
  logic wr;
  logic rd;
  logic alert_active;
  logic [7:0] next_rdata;

  assign wr = CE & REG_WR;
  assign rd = CE & REG_RD;

  // ----------------------------------------------------------------
  // Overtemperature pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      ot_meta <= 1'b0;
      ot_sync <= 1'b0;
    end else if (CE) begin
      ot_meta <= ~OVERTEMP_PIN_N;
      ot_sync <= ot_meta;
    end
  end

  // ----------------------------------------------------------------
  // Alert mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      alert_mask_volt_temp <= MAOT_RST_MASK_VT;
      alert_mask_fan_diode <= MAOT_RST_MASK_FD;
    end else if (wr) begin
      if (REG_ADDR == MAOT_OFS_MASK_VT) begin
        alert_mask_volt_temp <= REG_WDATA & MAOT_WMASK_MASK_VT;
      end
      if (REG_ADDR == MAOT_OFS_MASK_FD) begin
        alert_mask_fan_diode <= REG_WDATA & MAOT_WMASK_MASK_FD;
      end
    end
  end

  // Status inputs pass unmasked to their own registers; only the pin is gated
  assign alert_active = |(VOLT_TEMP_EVENTS & ~alert_mask_volt_temp & MAOT_WMASK_MASK_VT)
                      | |(FAN_DIODE_EVENTS & ~alert_mask_fan_diode & MAOT_WMASK_MASK_FD);

  // ----------------------------------------------------------------
  // Pin and tach configuration
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_and_tach_config <= MAOT_RST_CONFIG;
    end else if (wr && REG_ADDR == MAOT_OFS_CONFIG) begin
      pin_and_tach_config[7:4] <= REG_WDATA[7:4] & MAOT_WMASK_CFG_FREE[7:4];
      if (!LOCK) begin
        pin_and_tach_config[3:0] <= REG_WDATA[3:0] & MAOT_WMASK_CFG_LOCKABLE[3:0];
      end
    end
  end

  // Open drain alert pulls low; otherwise the pin carries the fan drive
  always_comb begin
    if (pin_and_tach_config[MAOT_CFG_ALERT_SEL]) begin
      SHARED_PIN_OUT = 1'b0;
      SHARED_PIN_OE = alert_active;
    end else begin
      SHARED_PIN_OUT = SECOND_FAN_DRIVE;
      SHARED_PIN_OE = 1'b1;
    end
  end

  // Fast selects a 250 ms measurement period instead of 1000 ms
  assign TACH_FAST = pin_and_tach_config[MAOT_CFG_TACH_FAST];
  // Continuous mode skips pulse stretching; only sane with dc fans
  assign TACH_CONTINUOUS = pin_and_tach_config[MAOT_CFG_CONT_LSB +: 4];

  // ----------------------------------------------------------------
  // Extended-resolution registers with read freeze
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend_volt <= 4'h0;
      pend_temp <= 4'h0;
    end else if (CE) begin
      if (rd && REG_ADDR == MAOT_OFS_LOW_VOLT) begin
        pend_volt <= 4'hf;
      end else begin
        pend_volt <= pend_volt & ~HIGH_VOLT_READ;
      end
      if (rd && REG_ADDR == MAOT_OFS_LOW_TEMP) begin
        pend_temp <= 4'hf;
      end else begin
        pend_temp <= pend_temp & ~HIGH_TEMP_READ;
      end
    end
  end

  assign FREEZE_VOLT_HIGH = |pend_volt;
  assign FREEZE_TEMP_HIGH = |pend_temp;

  always_ff @(posedge CLK) begin
    if (RST) begin
      low_bits_voltages <= MAOT_RST_LOW;
      low_bits_12v_temps <= MAOT_RST_LOW;
    end else if (CE) begin
      if (!FREEZE_VOLT_HIGH && !(rd && REG_ADDR == MAOT_OFS_LOW_VOLT)) begin
        low_bits_voltages <= LOW_BITS_VOLT_IN;
      end
      if (!FREEZE_TEMP_HIGH && !(rd && REG_ADDR == MAOT_OFS_LOW_TEMP)) begin
        low_bits_12v_temps <= LOW_BITS_TEMP_IN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Overtemperature timer and limit
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      overtemp_duration_limit <= MAOT_RST_OT_LIMIT;
    end else if (wr && REG_ADDR == MAOT_OFS_OT_LIMIT) begin
      overtemp_duration_limit <= REG_WDATA;
    end
  end

  assign tif.pin_active = ot_sync & pin_and_tach_config[MAOT_CFG_OT_ENABLE];
  assign tif.read_clear = rd && REG_ADDR == MAOT_OFS_OT_TIMER;
  assign tif.limit = overtemp_duration_limit;

  maot_overtemp_timer #(
    .STEP_CYCLES(OT_STEP_CYCLES)
  ) u_timer (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .tif(tif)
  );

  // A new hit in the clear cycle wins
  always_ff @(posedge CLK) begin
    if (RST) begin
      OVERTEMP_LIMIT_FLAG <= 1'b0;
    end else if (CE) begin
      if (tif.limit_hit) begin
        OVERTEMP_LIMIT_FLAG <= 1'b1;
      end else if (OVERTEMP_FLAG_CLEAR) begin
        OVERTEMP_LIMIT_FLAG <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    case (REG_ADDR)
      MAOT_OFS_MASK_VT: next_rdata = alert_mask_volt_temp;
      MAOT_OFS_MASK_FD: next_rdata = alert_mask_fan_diode;
      MAOT_OFS_LOW_VOLT: next_rdata = low_bits_voltages;
      MAOT_OFS_LOW_TEMP: next_rdata = low_bits_12v_temps;
      MAOT_OFS_CONFIG: next_rdata = pin_and_tach_config;
      MAOT_OFS_OT_TIMER: next_rdata = tif.value;
      MAOT_OFS_OT_LIMIT: next_rdata = overtemp_duration_limit;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (rd) begin
      REG_RDATA <= next_rdata;
    end
  end

endmodule : maot_alert_timer_regs

// [dv/maot_alert_timer_monitor.sv]
// Checker: port-level properties of the alert mask and overtemp timer bank
`timescale 1ns/1ps
module maot_regs_checker #(
  parameter int unsigned OT_STEP_CYCLES = 2276000
) (
  // Clock and register port
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic LOCK,
  // Status and pins
  input wire logic [7:0] VOLT_TEMP_EVENTS,
  input wire logic [7:0] FAN_DIODE_EVENTS,
  input wire logic [3:0] HIGH_VOLT_READ,
  input wire logic FREEZE_VOLT_HIGH,
  input wire logic SECOND_FAN_DRIVE,
  input wire logic SHARED_PIN_OUT,
  input wire logic SHARED_PIN_OE,
  input wire logic OVERTEMP_LIMIT_FLAG,
  input wire logic OVERTEMP_FLAG_CLEAR,
  input wire logic TACH_FAST,
  input wire logic [3:0] TACH_CONTINUOUS
);
  logic rd_ok;
  logic wr_ok;
  logic wr_cfg;
  logic may_show;
  logic exp_alert;
  logic exp_alert_mode;
  logic [7:0] exp_mask_vt;
  logic [7:0] exp_mask_fd;
  logic [31:0] since_clear;
  assign rd_ok = REG_RD && CE;
  assign wr_ok = REG_WR && CE;
  assign wr_cfg = wr_ok && (REG_ADDR == 8'h78);
  assign may_show = since_clear >= 2 * OT_STEP_CYCLES;
  // Any unmasked defined status bit; reserved positions never gate
  assign exp_alert = |(VOLT_TEMP_EVENTS[6:0] & ~exp_mask_vt[6:0])
                   || |({FAN_DIODE_EVENTS[7:2], FAN_DIODE_EVENTS[0]}
                        & ~{exp_mask_fd[7:2], exp_mask_fd[0]});
  // Shadow of masks and pin select as written, so pin checks need no internals
  always_ff @(posedge CLK) begin
    if (RST) begin
      exp_mask_vt <= 8'h00;
      exp_mask_fd <= 8'h00;
      exp_alert_mode <= 1'b0;
    end else if (wr_ok) begin
      if (REG_ADDR == 8'h74) begin
        exp_mask_vt <= REG_WDATA;
      end
      if (REG_ADDR == 8'h75) begin
        exp_mask_fd <= REG_WDATA;
      end
      if (REG_ADDR == 8'h78 && !LOCK) begin
        exp_alert_mode <= REG_WDATA[0];
      end
    end
  end
  // Upper bound on how long the count can have run since its last clear
  always_ff @(posedge CLK) begin
    if (RST || (rd_ok && REG_ADDR == 8'h79)) begin
      since_clear <= 32'h0;
    end else if (since_clear != 32'hffffffff) begin
      since_clear <= since_clear + 32'h1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_alert_mask_gate: assert property (
    exp_alert_mode |-> SHARED_PIN_OE == exp_alert && !SHARED_PIN_OUT)
    else $error("alert pin does not follow unmasked events");
  a_pwm_pin_follows: assert property (
    !exp_alert_mode |-> SHARED_PIN_OE && SHARED_PIN_OUT == SECOND_FAN_DRIVE)
    else $error("shared pin not following fan drive");
  a_rdata_holds: assert property (!rd_ok |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  a_mask_reserved: assert property (rd_ok && REG_ADDR == 8'h74 |=> !REG_RDATA[7])
    else $error("mask reserved bit set");
  a_cfg_reserved: assert property (rd_ok && REG_ADDR == 8'h78 |=> !REG_RDATA[2])
    else $error("config reserved bit set");
  a_timer_hidden: assert property (
    rd_ok && REG_ADDR == 8'h79 |=> REG_RDATA[7:1] == 7'h0 || $past(may_show))
    else $error("timer count visible too early");
  a_tach_cont_write: assert property (
    wr_cfg |=> TACH_CONTINUOUS == $past(REG_WDATA[7:4]))
    else $error("continuous bits not written");
  a_tach_fast_lock: assert property (wr_cfg && LOCK |=> $stable(TACH_FAST))
    else $error("locked rate bit changed");
  a_flag_sticky: assert property (
    OVERTEMP_LIMIT_FLAG && !OVERTEMP_FLAG_CLEAR |=> OVERTEMP_LIMIT_FLAG)
    else $error("limit flag dropped without clear");
  a_freeze_on_read: assert property (
    rd_ok && REG_ADDR == 8'h76 |=> FREEZE_VOLT_HIGH [*2])
    else $error("low-bit read did not freeze");
  a_freeze_release: assert property (
    $fell(FREEZE_VOLT_HIGH) |-> |$past(HIGH_VOLT_READ))
    else $error("freeze released without high read");
endmodule : maot_regs_checker

bind maot_alert_timer_regs maot_regs_checker #(.OT_STEP_CYCLES(OT_STEP_CYCLES)) maot_regs_checker_inst (
  .CLK, .RST, .CE, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA, .LOCK,
  .VOLT_TEMP_EVENTS, .FAN_DIODE_EVENTS, .HIGH_VOLT_READ, .FREEZE_VOLT_HIGH,
  .SECOND_FAN_DRIVE, .SHARED_PIN_OUT, .SHARED_PIN_OE, .OVERTEMP_LIMIT_FLAG,
  .OVERTEMP_FLAG_CLEAR, .TACH_FAST, .TACH_CONTINUOUS);

// [dv/maot_monitor_model.sv]
// Model: conversion engine and high-byte register reads beside the bank
`timescale 1ns/1ps
module maot_monitor_model (
  // Clock and freeze requests
  input wire logic clk,
  input wire logic freeze_volt,
  input wire logic freeze_temp,
  // Results and high-byte read strobes
  output logic [7:0] low_volt,
  output logic [7:0] low_temp,
  output logic [3:0] high_volt_read,
  output logic [3:0] high_temp_read
);
  logic [7:0] high_volt;
  logic [7:0] high_temp;
  initial begin
    low_volt = 8'h00;
    low_temp = 8'h80;
    high_volt_read = 4'h0;
    high_temp_read = 4'h0;
  end
  // Fresh results every cycle so a missed freeze shows
  // Plain always: the initial block above also writes these results
  always @(posedge clk) begin
    low_volt <= low_volt + 8'h01;
    low_temp <= low_temp + 8'h03;
    if (!freeze_volt) high_volt <= low_volt;
    if (!freeze_temp) high_temp <= low_temp;
  end
  task automatic read_high(input logic grp, input int ch);
    @(posedge clk);
    #1;
    if (grp) high_temp_read[ch] = 1'b1;
    else high_volt_read[ch] = 1'b1;
    @(posedge clk);
    #1;
    high_temp_read = 4'h0;
    high_volt_read = 4'h0;
  endtask : read_high
endmodule : maot_monitor_model

// [dv/tb_monitor_alert_mask_and_overtemp_timer.sv]
// Testbench: register, alert, freeze and overtemp timer scenarios
`timescale 1ns/1ps
module tb_monitor_alert_mask_and_overtemp_timer;
  logic CLK, RST, CE, REG_WR, REG_RD, LOCK, SECOND_FAN_DRIVE, OVERTEMP_PIN_N, OVERTEMP_FLAG_CLEAR;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, VOLT_TEMP_EVENTS, FAN_DIODE_EVENTS;
  logic [7:0] LOW_BITS_VOLT_IN, LOW_BITS_TEMP_IN, rdv, keep, keep_high;
  logic [3:0] HIGH_VOLT_READ, HIGH_TEMP_READ, TACH_CONTINUOUS;
  logic FREEZE_VOLT_HIGH, FREEZE_TEMP_HIGH, SHARED_PIN_OUT, SHARED_PIN_OE, OVERTEMP_LIMIT_FLAG;
  logic TACH_FAST;
  int num_errors = 0;
  int checked = 0;
  localparam logic [7:0] OFS [6] = '{8'h74, 8'h75, 8'h78, 8'h79, 8'h7a, 8'h80};
  localparam logic [7:0] RSTV [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
  maot_alert_timer_regs #(.OT_STEP_CYCLES(10)) maot_alert_timer_regs_inst (
    .CLK, .RST, .CE, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA, .LOCK,
    .VOLT_TEMP_EVENTS, .FAN_DIODE_EVENTS, .LOW_BITS_VOLT_IN, .LOW_BITS_TEMP_IN,
    .HIGH_VOLT_READ, .HIGH_TEMP_READ, .FREEZE_VOLT_HIGH, .FREEZE_TEMP_HIGH,
    .SECOND_FAN_DRIVE, .SHARED_PIN_OUT, .SHARED_PIN_OE, .OVERTEMP_PIN_N,
    .OVERTEMP_LIMIT_FLAG, .OVERTEMP_FLAG_CLEAR, .TACH_FAST, .TACH_CONTINUOUS);
  maot_monitor_model model_inst (.clk(CLK), .freeze_volt(FREEZE_VOLT_HIGH),
    .freeze_temp(FREEZE_TEMP_HIGH), .low_volt(LOW_BITS_VOLT_IN), .low_temp(LOW_BITS_TEMP_IN),
    .high_volt_read(HIGH_VOLT_READ), .high_temp_read(HIGH_TEMP_READ));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    cyc(1);
    REG_WR = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    cyc(1);
    REG_ADDR = a;
    REG_RD = 1'b1;
    cyc(1);
    REG_RD = 1'b0;
    rdv = REG_RDATA;
  endtask : rd
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk8(rdv, e);
  endtask : rdx
  // Pin held active for n cycles, then time for the synchroniser to settle
  task automatic pin(input int n);
    cyc(1);
    OVERTEMP_PIN_N = 1'b0;
    cyc(n);
    OVERTEMP_PIN_N = 1'b1;
    cyc(6);
  endtask : pin
  task automatic clr_flag;
    cyc(1);
    OVERTEMP_FLAG_CLEAR = 1'b1;
    cyc(1);
    OVERTEMP_FLAG_CLEAR = 1'b0;
  endtask : clr_flag
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    test_done;
  end
  initial begin
    {CE, RST, REG_WR, REG_RD, LOCK, SECOND_FAN_DRIVE, OVERTEMP_FLAG_CLEAR} = 7'b1100000;
    {REG_ADDR, REG_WDATA, VOLT_TEMP_EVENTS, FAN_DIODE_EVENTS} = 32'h0;
    OVERTEMP_PIN_N = 1'b1;
    cyc(20);
    RST = 1'b0;
    for (int i = 0; i < 6; i++) rdx(OFS[i], RSTV[i]);
    wr(8'h74, 8'hff);
    rdx(8'h74, 8'h7f);
    wr(8'h75, 8'hff);
    rdx(8'h75, 8'hfd);
    // Fans taken as dc-driven, so continuous mode is allowed on all four
    wr(8'h78, 8'hff);
    rdx(8'h78, 8'hfb);
    chk1(TACH_FAST, 1'b1);
    chk8({4'h0, TACH_CONTINUOUS}, 8'h0f);
    wr(8'h79, 8'hff);
    rdx(8'h79, 8'h00);
    // Alert mode: each status bit alone, unmasked then masked
    for (int i = 0; i < 16; i++) begin
      {FAN_DIODE_EVENTS, VOLT_TEMP_EVENTS} = 16'h1 << i;
      wr(8'h74, 8'h00);
      wr(8'h75, 8'h00);
      chk1(SHARED_PIN_OE, i != 7 && i != 9);
      wr(8'h74, VOLT_TEMP_EVENTS);
      wr(8'h75, FAN_DIODE_EVENTS);
      chk1(SHARED_PIN_OE, 1'b0);
    end
    CE = 1'b0;
    wr(8'h74, 8'h55);
    CE = 1'b1;
    rdx(8'h74, 8'h00);
    wr(8'h78, 8'h00);
    chk1(TACH_FAST, 1'b0);
    for (int i = 0; i < 2; i++) begin
      SECOND_FAN_DRIVE = i[0];
      cyc(1);
      chk1(SHARED_PIN_OE & (SHARED_PIN_OUT === i[0]), 1'b1);
    end
    wr(8'h78, 8'h09);
    LOCK = 1'b1;
    wr(8'h78, 8'hf6);
    rdx(8'h78, 8'hf9);
    LOCK = 1'b0;
    for (int g = 0; g < 2; g++) begin
      rd(8'h76 + 8'(g));
      keep = rdv;
      keep_high = g ? model_inst.high_temp : model_inst.high_volt;
      cyc(4);
      rdx(8'h76 + 8'(g), keep);
      chk8(g ? model_inst.high_temp : model_inst.high_volt, keep_high);
      for (int c = 0; c < 4; c++) begin
        chk1(g ? FREEZE_TEMP_HIGH : FREEZE_VOLT_HIGH, 1'b1);
        model_inst.read_high(g[0], c);
      end
      chk1(g ? FREEZE_TEMP_HIGH : FREEZE_VOLT_HIGH, 1'b0);
      rd(8'h76 + 8'(g));
      chk1(rdv !== keep, 1'b1);
    end
    // Pin function still off here, so an asserted pin must leave the timer idle
    pin(15);
    rdx(8'h79, 8'h00);
    wr(8'h78, 8'h02);
    rd(8'h79);
    pin(15);
    rdx(8'h79, 8'h01);
    rdx(8'h79, 8'h00);
    pin(55);
    rdx(8'h79, 8'h05);
    wr(8'h7a, 8'h00);
    OVERTEMP_PIN_N = 1'b0;
    cyc(6);
    chk1(OVERTEMP_LIMIT_FLAG, 1'b1);
    OVERTEMP_PIN_N = 1'b1;
    cyc(6);
    rd(8'h79);
    clr_flag;
    wr(8'h7a, 8'h02);
    OVERTEMP_PIN_N = 1'b0;
    cyc(26);
    chk1(OVERTEMP_LIMIT_FLAG, 1'b0);
    cyc(12);
    chk1(OVERTEMP_LIMIT_FLAG, 1'b1);
    OVERTEMP_PIN_N = 1'b1;
    cyc(6);
    test_done;
  end
endmodule : tb_monitor_alert_mask_and_overtemp_timer
